// File: shared/vsg_pkg.sv
// Constants, register map and drive-level encoding for the sensor-gate
// assignment and vertical-driver decode block.
// Assumes a 32-bit APB register bus with byte addresses.
package vsg_pkg;

    localparam int NUM_CHAN  = 24;
    localparam int LINE_W    = 13;
    localparam int PIX_W     = 13;
    localparam int ADDR_W    = 8;
    localparam int NUM_OUT   = 10;
    localparam int NUM_THREE = 9;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_SELECT     = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_PAIR       = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_MASK       = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_LINE_FIRST = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_LINE_SECND = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_CHAN_STATE = 8'h30;

    // Values after reset
    localparam logic [NUM_CHAN-1:0] RST_SELECT     = 24'h000000;
    localparam logic [NUM_CHAN-1:0] RST_PAIR       = 24'h000000;
    localparam logic [NUM_CHAN-1:0] RST_MASK       = 24'h000000;
    localparam logic [LINE_W-1:0]   RST_LINE_FIRST = 13'h0000;
    localparam logic [LINE_W-1:0]   RST_LINE_SECND = 13'h1FFF;

    // Fixed wiring: three-level output k is gated by channel GATE_BASE+k (0-based)
    localparam int GATE_BASE  = 15;
    localparam int PHASE7_CH  = 6;
    localparam int XFER_IDX [NUM_THREE] = '{0, 0, 1, 1, 2, 2, 3, 4, 5};

    typedef enum logic [2:0] {
        drive_level_high   = 3'b001,
        drive_level_middle = 3'b010,
        drive_level_low    = 3'b100
    } drive_level_e;

endpackage

// File: shared/drv_if.sv
// Carrier between the channel stage and the level decoder.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface drv_if;
    import vsg_pkg::*;

    logic [NUM_CHAN-1:0] chan;
    drive_level_e        level [NUM_OUT];

    modport src (output chan, input level);
    modport dec (input chan, output level);
endinterface
`default_nettype wire

// File: hw/vdrv_level_decode.sv
// Fixed decode of channel pairs onto three-level and two-level driver codes.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module vdrv_level_decode
    import vsg_pkg::*;
(
    // Channel vector in, levels out
    drv_if.dec drv
);

    function automatic drive_level_e level3(input logic xfer, input logic gate);
        if (xfer) begin
            return drive_level_low;
        end
        return gate ? drive_level_middle : drive_level_high;
    endfunction

    function automatic drive_level_e level2(input logic xfer);
        return xfer ? drive_level_low : drive_level_middle;
    endfunction

    // Phases 1..6: pairs A/B for 1..3, single for 4..6
    for (genvar k = 0; k < NUM_THREE; k++) begin : g_three
        assign drv.level[k] = level3(drv.chan[XFER_IDX[k]], drv.chan[GATE_BASE+k]); // [RULE_07]
    end

    assign drv.level[NUM_OUT-1] = level2(drv.chan[PHASE7_CH]); // [RULE_12]

endmodule
`default_nettype wire

// File: hw/vsg_select_vdriver_decode.sv
// Sensor-gate pulse assignment per timing channel and vertical-driver
// level decode, with an APB register slave.
// Assumes line/pixel counters, toggle positions, start polarities and the
// ordinary transfer pulses come from the pattern generator on CLK.
//
// What this block does
// [RULE_01] Select bit turns channel into sensor-gate pulse
// [RULE_02] Pair bit picks toggles one/two or three/four
// [RULE_03] Mask bit suppresses that channel's gate pulse
// [RULE_04] First line number places the gate pulses
// [RULE_05] Second line repeats pulses; software disables
// [RULE_06] Pulse from polarity, two edges, active line
// [RULE_07] Three-level decode: low/low high, gate middle
// [RULE_08] Phase one pair: channel 1, gates 16/17
// [RULE_09] Phase two pair: channel 2, gates 18/19
// [RULE_10] Phase three pair: channel 3, gates 20/21
// [RULE_11] Phases four-six: channels 4-6, gates 22-24
// [RULE_12] Phase seven two-level from channel 7 only
// [RULE_13] Software programs select to channels 16-24
// [RULE_14] Masked gate channel holds start polarity
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module vsg_select_vdriver_decode
    import vsg_pkg::*;
(
    // Clock, reset, enable
    input  wire  logic                CLK,
    input  wire  logic                RST_N,
    input  wire  logic                CE,
    // APB slave
    input  wire  logic                PSEL,
    input  wire  logic                PENABLE,
    input  wire  logic                PWRITE,
    input  wire  logic [ADDR_W-1:0]   PADDR,
    input  wire  logic [31:0]         PWDATA,
    output logic       [31:0]         PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    // Field timing from the pattern generator
    input  wire  logic [LINE_W-1:0]   LINE_NUM,
    input  wire  logic [PIX_W-1:0]    PIXEL_NUM,
    input  wire  logic [NUM_CHAN-1:0] VERTICAL_TIMING_CHANNEL_IN,
    input  wire  logic [NUM_CHAN-1:0] START_POLARITY,
    input  wire  logic [PIX_W-1:0]    TOGGLE_POSITION_ONE,
    input  wire  logic [PIX_W-1:0]    TOGGLE_POSITION_TWO,
    input  wire  logic [PIX_W-1:0]    TOGGLE_POSITION_THREE,
    input  wire  logic [PIX_W-1:0]    TOGGLE_POSITION_FOUR,
    // Driver level codes toward the electrodes
    output var   drive_level_e        PHASE1_OUT_A,
    output var   drive_level_e        PHASE1_OUT_B,
    output var   drive_level_e        PHASE2_OUT_A,
    output var   drive_level_e        PHASE2_OUT_B,
    output var   drive_level_e        PHASE3_OUT_A,
    output var   drive_level_e        PHASE3_OUT_B,
    output var   drive_level_e        PHASE4_OUT,
    output var   drive_level_e        PHASE5_OUT,
    output var   drive_level_e        PHASE6_OUT,
    output var   drive_level_e        PHASE7_OUT
);

    // Reset release through two flops
    logic                rst_meta_reg;
    logic                rst_n_sync;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync   <= 1'b0;
        end else if (CE) begin
            rst_meta_reg <= 1'b1;
            rst_n_sync   <= rst_meta_reg;
        end
    end

    // Registers
    logic [NUM_CHAN-1:0] select_reg;
    logic [NUM_CHAN-1:0] pair_reg;
    logic [NUM_CHAN-1:0] mask_reg;
    logic [LINE_W-1:0]   line_first_reg;
    logic [LINE_W-1:0]   line_secnd_reg;
    logic [NUM_CHAN-1:0] chan_reg;
    logic [NUM_CHAN-1:0] chan_next;
    logic [31:0]         prdata_reg;
    logic                pready_reg;
    logic                pslverr_reg;
    drive_level_e        level_reg [NUM_OUT];

    // APB decode
    wire                 apb_access = PSEL & PENABLE;
    wire                 apb_first  = apb_access & ~pready_reg;
    wire                 apb_take   = apb_access & pready_reg;
    wire                 hit_select = (PADDR == OFS_SELECT);
    wire                 hit_pair   = (PADDR == OFS_PAIR);
    wire                 hit_mask   = (PADDR == OFS_MASK);
    wire                 hit_line1  = (PADDR == OFS_LINE_FIRST);
    wire                 hit_line2  = (PADDR == OFS_LINE_SECND);
    wire                 hit_state  = (PADDR == OFS_CHAN_STATE);
    wire                 hit_any    = hit_select | hit_pair | hit_mask | hit_line1 | hit_line2 | hit_state;
    wire                 wr_take    = apb_take & PWRITE & ~pslverr_reg;
    wire [31:0]          rd_mux     = hit_select ? {8'h00, select_reg} :
                                      hit_pair   ? {8'h00, pair_reg} :
                                      hit_mask   ? {8'h00, mask_reg} :
                                      hit_line1  ? {19'h00000, line_first_reg} :
                                      hit_line2  ? {19'h00000, line_secnd_reg} :
                                      hit_state  ? {8'h00, chan_reg} : 32'h00000000;

    // One wait state: data and status are ready on the second access cycle
    always_ff @(posedge CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end else if (CE) begin
            pready_reg  <= apb_first;
            pslverr_reg <= apb_first & ~hit_any;
            if (apb_first && !PWRITE) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            select_reg     <= RST_SELECT;
            pair_reg       <= RST_PAIR;
            mask_reg       <= RST_MASK;
            line_first_reg <= RST_LINE_FIRST;
            line_secnd_reg <= RST_LINE_SECND;
        end else if (CE && wr_take) begin
            if (hit_select) begin
                select_reg <= PWDATA[NUM_CHAN-1:0]; // [RULE_01]
            end
            if (hit_pair) begin
                pair_reg <= PWDATA[NUM_CHAN-1:0]; // [RULE_02]
            end
            if (hit_mask) begin
                mask_reg <= PWDATA[NUM_CHAN-1:0]; // [RULE_03]
            end
            if (hit_line1) begin
                line_first_reg <= PWDATA[LINE_W-1:0]; // [RULE_04]
            end
            if (hit_line2) begin
                line_secnd_reg <= PWDATA[LINE_W-1:0]; // [RULE_05]
            end
        end
    end

    assign PRDATA  = prdata_reg;
    assign PREADY  = pready_reg;
    assign PSLVERR = pslverr_reg;

    // Channel stage
    function automatic logic [PIX_W-1:0] pick_edge(input logic sel,
                                                   input logic [PIX_W-1:0] a,
                                                   input logic [PIX_W-1:0] b);
        return sel ? b : a;
    endfunction

    wire                 on_line_first = (LINE_NUM == line_first_reg); // [RULE_04]
    wire                 on_line_secnd = (LINE_NUM == line_secnd_reg); // [RULE_05]
    wire                 active_line   = on_line_first | on_line_secnd;

    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
        wire [PIX_W-1:0] edge_a   = pick_edge(pair_reg[i], TOGGLE_POSITION_ONE, TOGGLE_POSITION_THREE); // [RULE_02]
        wire [PIX_W-1:0] edge_b   = pick_edge(pair_reg[i], TOGGLE_POSITION_TWO, TOGGLE_POSITION_FOUR);
        wire             in_win   = (PIXEL_NUM >= edge_a) && (PIXEL_NUM < edge_b);
        wire             fire     = active_line & ~mask_reg[i]; // [RULE_03] [RULE_14]
        wire             gate_val = START_POLARITY[i] ^ (fire & in_win); // [RULE_06]
        assign chan_next[i] = select_reg[i] ? gate_val : VERTICAL_TIMING_CHANNEL_IN[i]; // [RULE_01]
    end

    always_ff @(posedge CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            chan_reg <= '0;
        end else if (CE) begin
            chan_reg <= chan_next;
        end
    end

    // Level decode and output registers
    drv_if drv ();

    assign drv.chan = chan_reg;

    vdrv_level_decode u_decode (
        .drv (drv.dec)
    );

    for (genvar k = 0; k < NUM_OUT; k++) begin : g_out
        always_ff @(posedge CLK or negedge rst_n_sync) begin
            if (!rst_n_sync) begin
                level_reg[k] <= drive_level_high;
            end else if (CE) begin
                level_reg[k] <= drv.level[k];
            end
        end
    end

    assign PHASE1_OUT_A = level_reg[0]; // [RULE_08]
    assign PHASE1_OUT_B = level_reg[1]; // [RULE_08]
    assign PHASE2_OUT_A = level_reg[2]; // [RULE_09]
    assign PHASE2_OUT_B = level_reg[3]; // [RULE_09]
    assign PHASE3_OUT_A = level_reg[4]; // [RULE_10]
    assign PHASE3_OUT_B = level_reg[5]; // [RULE_10]
    assign PHASE4_OUT   = level_reg[6]; // [RULE_11]
    assign PHASE5_OUT   = level_reg[7]; // [RULE_11]
    assign PHASE6_OUT   = level_reg[8]; // [RULE_11]
    assign PHASE7_OUT   = level_reg[9]; // [RULE_12]

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n_sync);

    sequence s_xfer_ch1_high;
        CE && chan_reg[0];
    endsequence

    sequence s_gate16_only;
        CE && !chan_reg[0] && chan_reg[15];
    endsequence

    sequence s_gate_line1_win;
        CE && select_reg[15] && !mask_reg[15] && pair_reg[15] && on_line_first
            && (PIXEL_NUM == TOGGLE_POSITION_THREE) && (TOGGLE_POSITION_THREE < TOGGLE_POSITION_FOUR);
    endsequence

    sequence s_gate_line2_win;
        CE && select_reg[16] && !mask_reg[16] && !pair_reg[16] && on_line_secnd
            && (PIXEL_NUM == TOGGLE_POSITION_ONE) && (TOGGLE_POSITION_ONE < TOGGLE_POSITION_TWO);
    endsequence

    xfer_pass_a: assert property (CE && !select_reg[0] // [RULE_01]
        |=> chan_reg[0] == $past(VERTICAL_TIMING_CHANNEL_IN[0]))
        else $error("Unselected channel did not follow its transfer pulse");

    sel_write_a: assert property (CE && wr_take && hit_select // [RULE_01]
        |=> select_reg == $past(PWDATA[NUM_CHAN-1:0]))
        else $error("Selection register did not take the written word");

    pair_three_a: assert property (s_gate_line1_win |=> chan_reg[15] != $past(START_POLARITY[15])) // [RULE_02]
        else $error("Gate pulse missing at third toggle on first line");

    mask_hold_a: assert property (CE && select_reg[17] && mask_reg[17] // [RULE_03] [RULE_14]
        |=> chan_reg[17] == $past(START_POLARITY[17]))
        else $error("Masked gate channel left its start polarity");

    off_line_a: assert property (CE && select_reg[17] && !active_line // [RULE_04]
        |=> chan_reg[17] == $past(START_POLARITY[17]))
        else $error("Gate pulse outside the active lines");

    repeat_line_a: assert property (s_gate_line2_win |=> chan_reg[16] != $past(START_POLARITY[16])) // [RULE_05]
        else $error("Gate pulse not repeated on second line");

    pulse_end_a: assert property (CE && select_reg[18] && !pair_reg[18] && active_line // [RULE_06]
        && (PIXEL_NUM == TOGGLE_POSITION_TWO) |=> chan_reg[18] == $past(START_POLARITY[18]))
        else $error("Gate pulse did not end at its second edge");

    xfer_low_a: assert property (s_xfer_ch1_high // [RULE_07]
        |=> PHASE1_OUT_A == drive_level_low && PHASE1_OUT_B == drive_level_low)
        else $error("High transfer input did not give low level");

    phase1_gate_a: assert property (s_gate16_only |=> PHASE1_OUT_A == drive_level_middle) // [RULE_08]
        else $error("Phase one A not gated by channel sixteen");

    phase1b_gate_a: assert property (CE && !chan_reg[0] && chan_reg[16] // [RULE_08]
        |=> PHASE1_OUT_B == drive_level_middle)
        else $error("Phase one B not gated by channel seventeen");

    phase2_idle_a: assert property (CE && !chan_reg[1] && !chan_reg[18] // [RULE_09]
        |=> PHASE2_OUT_B == drive_level_high)
        else $error("Phase two B not high with both inputs low");

    phase2a_gate_a: assert property (CE && !chan_reg[1] && chan_reg[17] // [RULE_09]
        |=> PHASE2_OUT_A == drive_level_middle)
        else $error("Phase two A not gated by channel eighteen");

    phase3_gate_a: assert property (CE && !chan_reg[2] && chan_reg[19] // [RULE_10]
        |=> PHASE3_OUT_A == drive_level_middle)
        else $error("Phase three A not gated by channel twenty");

    phase3b_low_a: assert property (CE && chan_reg[2] // [RULE_10]
        |=> PHASE3_OUT_B == drive_level_low)
        else $error("Phase three B not low with transfer input high");

    phase4_gate_a: assert property (CE && !chan_reg[3] && chan_reg[21] // [RULE_11]
        |=> PHASE4_OUT == drive_level_middle)
        else $error("Phase four not gated by channel twenty-two");

    phase5_gate_a: assert property (CE && !chan_reg[4] && chan_reg[22] // [RULE_11]
        |=> PHASE5_OUT == drive_level_middle)
        else $error("Phase five not gated by channel twenty-three");

    phase6_gate_a: assert property (CE && !chan_reg[5] && chan_reg[23] // [RULE_11]
        |=> PHASE6_OUT == drive_level_middle)
        else $error("Phase six not gated by channel twenty-four");

    phase7_two_a: assert property (CE |=> PHASE7_OUT == (($past(chan_reg[6])) ? drive_level_low // [RULE_12]
        : drive_level_middle))
        else $error("Phase seven level wrong");

    apb_wait_a: assert property (CE && apb_first |=> pready_reg ##1 !pready_reg)
        else $error("Register bus answer not one wait state");

    sequence s_bus_miss;
        CE && apb_first && !hit_any;
    endsequence

    bus_error_a: assert property (s_bus_miss |=> PSLVERR && PREADY)
        else $error("Unmapped address did not answer with an error");

    freeze_hold_a: assert property (!CE |=> $stable(chan_reg) && $stable(select_reg) && $stable(PHASE7_OUT))
        else $error("State moved while the clock enable was low");

endmodule
`default_nettype wire

// File: verification/ccd_electrode_model.sv
// Far-side model of the sensor electrodes fed by the ten phase drive codes.
// Assumes the codes change only just after rising CLK edges.
`timescale 1ns/1ps
`default_nettype none
module ccd_electrode_model
    import vsg_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Electrode drive codes
    input  wire drive_level_e lvl [NUM_OUT],
    // Sticky flag: a code was not one of the three levels
    output logic              code_bad
);
    // An electrode only understands the three one-hot levels
    always @(posedge clk) begin
        if (!rst_n) begin
            code_bad <= 1'b0;
        end else begin
            for (int k = 0; k < NUM_OUT; k++) begin
                if (!(lvl[k] inside {drive_level_high, drive_level_middle, drive_level_low})) begin
                    code_bad <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/test_vsg_select_vdriver_decode.sv
// Self-checking bench: APB register access, fixed level decode, gate pulse placement.
// Assumes the one-wait-state APB slave and two-edge timing latency of the block.
`timescale 1ns/1ps
`default_nettype none
module test_vsg_select_vdriver_decode;
    import vsg_pkg::*;

    logic                clk;
    logic                rst_n;
    logic                ce;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [31:0]         pwdata;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic [LINE_W-1:0]   line_num;
    logic [PIX_W-1:0]    pixel_num;
    logic [NUM_CHAN-1:0] chan_in;
    logic [NUM_CHAN-1:0] start_pol;
    logic [PIX_W-1:0]    tog [4];
    drive_level_e        lvl [NUM_OUT];
    logic                code_bad;
    int                  miscompares = 0;
    int                  checked = 0;

    vsg_select_vdriver_decode u_vsg_select_vdriver_decode (
        .CLK(clk), .RST_N(rst_n), .CE(ce),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .LINE_NUM(line_num), .PIXEL_NUM(pixel_num), .START_POLARITY(start_pol),
        .VERTICAL_TIMING_CHANNEL_IN(chan_in),
        .TOGGLE_POSITION_ONE(tog[0]), .TOGGLE_POSITION_TWO(tog[1]),
        .TOGGLE_POSITION_THREE(tog[2]), .TOGGLE_POSITION_FOUR(tog[3]),
        .PHASE1_OUT_A(lvl[0]), .PHASE1_OUT_B(lvl[1]), .PHASE2_OUT_A(lvl[2]), .PHASE2_OUT_B(lvl[3]),
        .PHASE3_OUT_A(lvl[4]), .PHASE3_OUT_B(lvl[5]), .PHASE4_OUT(lvl[6]), .PHASE5_OUT(lvl[7]),
        .PHASE6_OUT(lvl[8]), .PHASE7_OUT(lvl[9])
    );

    ccd_electrode_model u_ccd_electrode_model (.clk(clk), .rst_n(rst_n), .lvl(lvl), .code_bad(code_bad));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic test_done;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_lvl(input drive_level_e got, input drive_level_e exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: level %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until PREADY is seen high at an edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            test_done();
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h00000000, r, e);
        cmp_reg(r, exp);
        cmp_reg({31'h00000000, e}, {31'h00000000, exp_err});
    endtask

    function automatic drive_level_e lvl_of(input logic x, input logic g);
        if (x) begin
            return drive_level_low;
        end
        return g ? drive_level_middle : drive_level_high;
    endfunction

    // Expected codes of all ten outputs from a channel vector
    task automatic check_all(input logic [NUM_CHAN-1:0] ch);
        for (int k = 0; k < NUM_THREE; k++) begin
            cmp_lvl(lvl[k], lvl_of(ch[XFER_IDX[k]], ch[GATE_BASE+k]));
        end
        cmp_lvl(lvl[9], lvl_of(ch[PHASE7_CH], 1'b1));
    endtask

    task automatic drive(input logic [12:0] ln, input logic [12:0] px, input logic [23:0] cv,
                         input logic [23:0] pol);
        @(posedge clk);
        line_num <= ln;
        pixel_num <= px;
        chan_in <= cv;
        start_pol <= pol;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic gate_case(input logic [12:0] ln, input logic [12:0] px, input logic [23:0] pol,
                             input logic [23:0] exp);
        drive(ln, px, 24'h100005, pol);
        check_all(exp);
        rd_chk(OFS_CHAN_STATE, {8'h00, exp}, 1'b0);
    endtask

    initial begin
        #200000;
        miscompares++;
        test_done();
    end

    initial begin
        logic [23:0] chan_vec;
        rst_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        line_num = 13'h0000;
        pixel_num = 13'h0000;
        chan_in = 24'h000000;
        start_pol = 24'h000000;
        tog = '{13'h000A, 13'h0014, 13'h001E, 13'h0028};
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(OFS_SELECT, 32'(RST_SELECT), 1'b0);
        rd_chk(OFS_PAIR, 32'(RST_PAIR), 1'b0);
        rd_chk(OFS_MASK, 32'(RST_MASK), 1'b0);
        rd_chk(OFS_LINE_FIRST, 32'(RST_LINE_FIRST), 1'b0);
        rd_chk(OFS_LINE_SECND, 32'(RST_LINE_SECND), 1'b0);
        rd_chk(8'h40, 32'h00000000, 1'b1);
        // Nothing selected: every channel passes the transfer input
        for (int k = 0; k < NUM_THREE; k++) begin
            for (int c = 0; c < 4; c++) begin
                chan_vec = 24'h000000;
                chan_vec[XFER_IDX[k]] = c[1];
                chan_vec[GATE_BASE+k] = c[0];
                chan_vec[PHASE7_CH] = c[0];
                drive(13'h0000, 13'h0000, chan_vec, 24'h000000);
                check_all(chan_vec);
            end
        end
        wr(OFS_SELECT, 32'h00FF8000);
        rd_chk(OFS_SELECT, 32'h00FF8000, 1'b0);
        wr(OFS_PAIR, 32'hFFFFFFFF);
        rd_chk(OFS_PAIR, 32'h00FFFFFF, 1'b0);
        wr(OFS_PAIR, 32'h00008000);
        wr(OFS_LINE_FIRST, 32'h0000E005);
        rd_chk(OFS_LINE_FIRST, 32'h00000005, 1'b0);
        wr(OFS_LINE_SECND, 32'h00000009);
        gate_case(13'd5, 13'd12, 24'h000000, 24'hFF0005);
        gate_case(13'd5, 13'd30, 24'h000000, 24'h008005);
        gate_case(13'd5, 13'd20, 24'h000000, 24'h000005);
        gate_case(13'd9, 13'd10, 24'h000000, 24'hFF0005);
        gate_case(13'd6, 13'd12, 24'h000000, 24'h000005);
        wr(OFS_MASK, 32'h00030000);
        rd_chk(OFS_MASK, 32'h00030000, 1'b0);
        gate_case(13'd5, 13'd12, 24'h020000, 24'hFE0005);
        gate_case(13'd6, 13'd12, 24'h020000, 24'h020005);
        // Enable low: moving to the active line must not reach the outputs
        @(posedge clk);
        ce <= 1'b0;
        line_num <= 13'd5;
        repeat (3) @(posedge clk);
        #1;
        check_all(24'h020005);
        @(posedge clk);
        ce <= 1'b1;
        cmp_reg({31'h00000000, code_bad}, 32'h00000000);
        test_done();
    end
endmodule
`default_nettype wire
